/* File: pkg/dbgtr_pkg.sv */
/*
 * shared constants and types of the debug trace and trigger unit:
 * apb register offsets, field positions, reset values, trigger modes,
 * change-of-flow kinds and the packed cpu bus observation record.
 * assumes a 32-bit apb with byte addresses, one register per word.
 */
package dbgtr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;  // debug_control_reg
  localparam logic [7:0] OFS_TRIG = 8'h04;  // trigger_control_reg
  localparam logic [7:0] OFS_STAT = 8'h08;  // debug_status_reg
  localparam logic [7:0] OFS_CMPA = 8'h0c;  // comparator a value
  localparam logic [7:0] OFS_CMPB = 8'h10;  // comparator b value
  localparam logic [7:0] OFS_FIFOH = 8'h14; // fifo_data_high
  localparam logic [7:0] OFS_FIFOL = 8'h18; // fifo_data_low

  // debug_control_reg fields
  localparam int CTRL_MOD_EN = 7;   // module_enable
  localparam int CTRL_RUN = 6;      // run enable, reads run_active_flag
  localparam int CTRL_TAG = 5;      // 1 tag request, 0 force request
  localparam int CTRL_BRK_EN = 4;   // cpu_break_enable
  localparam int CTRL_A_DEN = 3;    // comp_a_dir_check_en
  localparam int CTRL_A_DVAL = 2;   // comp_a_dir_value, 1 = read
  localparam int CTRL_B_DEN = 1;    // comp_b_dir_check_en
  localparam int CTRL_B_DVAL = 0;   // comp_b_dir_value, 1 = read

  // trigger_control_reg fields
  localparam int TRIG_QUAL = 7;     // opcode_qualify_select
  localparam int TRIG_BEGIN = 6;    // 1 begin trace, 0 end trace
  localparam int TRIG_MODE_LO = 0;  // trigger_mode_field low bit

  // debug_status_reg fields
  localparam int STAT_AF = 7;       // comp_a_hit_flag
  localparam int STAT_BF = 6;       // comp_b_hit_flag
  localparam int STAT_ARM = 5;      // run_active_flag
  localparam int STAT_CNT_LO = 0;   // fifo_valid_count low bit

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;

  // fifo geometry and timing
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] CNT_FULL = 4'h8;
  localparam logic [1:0] COF_BLANK = 2'h2; // bus cycles blanked after start

  // trigger modes, consecutive codes from zero
  typedef enum logic [3:0] {
    MODE_A_ONLY, MODE_A_OR_B, MODE_A_THEN_B, MODE_FULL_AB, MODE_FULL_ANB,
    MODE_EVT_B, MODE_A_THEN_EVT_B, MODE_INSIDE, MODE_OUTSIDE
  } dbgtr_mode_e;

  // change-of-flow kinds reported by the core
  typedef enum logic [1:0] {
    COF_COND, COF_UNCOND, COF_INDIRECT, COF_RETURN
  } dbgtr_cof_e;

  // run sequencer states
  typedef enum logic [1:0] {
    RUN_IDLE, RUN_WAIT, RUN_STORE, RUN_CIRC
  } dbgtr_run_e;

  // one cpu bus cycle as seen by the unit
  typedef struct packed {
    logic [15:0] addr;      // cpu address
    logic [7:0] rdata;      // read data bus
    logic [7:0] wdata;      // write data bus
    logic rd;               // 1 read, 0 write
    logic valid;            // bus cycle present
    logic opfetch;          // cycle is an opcode fetch
    logic exec;             // opcode starts executing, pulse
    logic [15:0] exec_addr; // address of that opcode
    logic cof_valid;        // change of flow this cycle, pulse
    dbgtr_cof_e cof_kind;   // kind of change of flow
    logic [15:0] cof_src;   // address of the flow opcode
    logic [15:0] cof_dst;   // run-time destination
  } dbgtr_cpu_s;

endpackage : dbgtr_pkg

/* File: rtl/dbgtr_top.sv */
/*
 * debug trace and trigger unit: two 16-bit comparators, nine trigger
 * modes, an eight entry trace fifo read through high and low data ports,
 * and tag or force break requests to the core.
 * assumes apb3 from software, a core that reports bus cycles, executed
 * opcodes and change-of-flow events synchronously to I_CLOCK, and that
 * acknowledges a force request once its current instruction completes.
 */
`timescale 1ns/1ps

module dbgtr_top
  import dbgtr_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire dbgtr_cpu_s I_CPU,
  input wire logic I_ENTER_BACKGROUND_INSTR_ACCESS,
  input wire logic I_BRK_ACK,
  output logic O_BRK_TAG,
  output logic O_BRK_FORCE,
  output logic O_ARMED
);

  // software state
  logic [7:0] ctrl_q;               // control bits
  logic [7:0] trig_q;               // trigger control bits
  logic [15:0] cmp_q [2];           // comparator values a, b
  logic af_q;                       // comp_a_hit_flag
  logic bf_q;                       // comp_b_hit_flag
  logic [3:0] cnt_q;                // fifo_valid_count
  logic [15:0] fifo_q [FIFO_DEPTH]; // entry 0 is the read port
  dbgtr_run_e run_q;                // run sequencer
  logic [1:0] blank_q;              // begin-trace blanking counter
  logic [15:0] fetch_q;             // last opcode fetch address
  logic [31:0] prdata_q;            // read data
  logic slverr_q;                   // unmapped address flag
  logic tag_q;                      // tag break pulse
  logic force_q;                    // force break request

  // bus decode
  logic setup;                      // apb setup phase
  logic acc;                        // apb access phase, one cycle
  logic wr_ctrl;                    // control write
  logic rd_low;                     // low fifo byte read
  logic arm_req;                    // run and module enable written one
  logic stop_req;                   // run or module enable cleared
  dbgtr_mode_e mode;                // decoded trigger mode

  // match network
  logic [1:0] raw;                  // direction qualified address hits
  logic [1:0] pend_q;               // opcode tracking pending
  logic [1:0] exe;                  // tracked opcode executed
  logic [1:0] hit;                  // hits used by the modes
  logic [7:0] data_bus;             // data for comparator b
  logic data_eq;                    // data equals comparator b low
  logic in_rng;                     // inside range
  logic trig;                       // qualified trigger
  logic evt_mode;                   // event-only mode
  logic full_mode;                  // address plus data mode
  logic cof_ok;                     // storable change of flow
  logic [15:0] cof_addr;            // address to store
  logic do_store;                   // write one entry
  logic do_shift;                   // shift the fifo
  logic [15:0] din;                 // entry shifted in
  logic brk;                        // break request cause
  logic stop_shift;                 // early stop realignment

  assign setup = I_PSEL && !I_PENABLE;
  assign acc = I_PSEL && I_PENABLE;
  assign wr_ctrl = acc && I_PWRITE && (I_PADDR == OFS_CTRL);
  assign rd_low = acc && !I_PWRITE && (I_PADDR == OFS_FIFOL);
  assign arm_req = wr_ctrl && I_PWDATA[CTRL_RUN] && I_PWDATA[CTRL_MOD_EN];
  assign stop_req = wr_ctrl && !(I_PWDATA[CTRL_RUN] &&
                    I_PWDATA[CTRL_MOD_EN]);

  // mode decode, unknown codes fall back to a-only
  always_comb begin
    case (trig_q[TRIG_MODE_LO +: 4])
      MODE_A_OR_B: mode = MODE_A_OR_B;
      MODE_A_THEN_B: mode = MODE_A_THEN_B;
      MODE_FULL_AB: mode = MODE_FULL_AB;
      MODE_FULL_ANB: mode = MODE_FULL_ANB;
      MODE_EVT_B: mode = MODE_EVT_B;
      MODE_A_THEN_EVT_B: mode = MODE_A_THEN_EVT_B;
      MODE_INSIDE: mode = MODE_INSIDE;
      MODE_OUTSIDE: mode = MODE_OUTSIDE;
      default: mode = MODE_A_ONLY;
    endcase
  end

  assign evt_mode = (mode == MODE_EVT_B) || (mode == MODE_A_THEN_EVT_B);
  assign full_mode = (mode == MODE_FULL_AB) || (mode == MODE_FULL_ANB);

  // per comparator address match and opcode tracking
  generate
    for (genvar c = 0; c < 2; c++) begin : g_cmp
      logic den; // direction check enable
      logic dval; // direction to match
      assign den = ctrl_q[c == 0 ? CTRL_A_DEN : CTRL_B_DEN];
      assign dval = ctrl_q[c == 0 ? CTRL_A_DVAL : CTRL_B_DVAL];
      // masked during serial link accesses
      assign raw[c] = I_CPU.valid && !I_ENTER_BACKGROUND_INSTR_ACCESS &&
                      (I_CPU.addr == cmp_q[c]) &&
                      (!den || (I_CPU.rd == dval));
      assign exe[c] = pend_q[c] && I_CPU.exec &&
                      (I_CPU.exec_addr == cmp_q[c]);
      // tracker armed by a matching fetch, fires on execution
      always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          pend_q[c] <= 1'b0;
        end else if (raw[c] && I_CPU.opfetch) begin
          pend_q[c] <= 1'b1;
        end else if (exe[c]) begin
          pend_q[c] <= 1'b0;
        end
      end
      assign hit[c] = trig_q[TRIG_QUAL] ? exe[c] : raw[c];
    end
  endgenerate

  // data compare bus choice
  assign data_bus = (ctrl_q[CTRL_A_DEN] && !ctrl_q[CTRL_A_DVAL]) ?
                    I_CPU.wdata : I_CPU.rdata;
  assign data_eq = (data_bus == cmp_q[1][7:0]);
  assign in_rng = (I_CPU.addr >= cmp_q[0]) && (I_CPU.addr <= cmp_q[1]);

  // trigger per mode
  always_comb begin
    case (mode)
      MODE_A_OR_B: trig = hit[0] || hit[1];
      MODE_A_THEN_B: trig = hit[1] && af_q;
      MODE_FULL_AB: trig = hit[0] && data_eq;
      MODE_FULL_ANB: trig = hit[0] && !data_eq;
      MODE_EVT_B: trig = hit[1];
      MODE_A_THEN_EVT_B: trig = hit[1] && af_q;
      MODE_INSIDE: begin
        trig = I_CPU.valid && !I_ENTER_BACKGROUND_INSTR_ACCESS && in_rng;
      end
      MODE_OUTSIDE: begin
        trig = I_CPU.valid && !I_ENTER_BACKGROUND_INSTR_ACCESS && !in_rng;
      end
      default: trig = hit[0];
    endcase
  end

  // change-of-flow address choice
  assign cof_ok = I_CPU.cof_valid && (I_CPU.cof_kind != COF_UNCOND);
  assign cof_addr = (I_CPU.cof_kind == COF_COND) ?
                    I_CPU.cof_src : I_CPU.cof_dst;

  // what enters the fifo this cycle
  always_comb begin
    do_store = 1'b0;
    din = 16'h0000;
    case (run_q)
      RUN_STORE: begin
        if (evt_mode) begin
          do_store = trig;
          din = {8'h00, data_bus};
        end else begin
          do_store = cof_ok && (blank_q == 2'h0);
          din = cof_addr;
        end
      end
      RUN_CIRC: begin
        do_store = cof_ok;
        din = cof_addr;
      end
      default: begin
        // profiling when unarmed, zero fill otherwise
        din = (run_q == RUN_IDLE) ? fetch_q : 16'h0000;
      end
    endcase
  end

  assign stop_shift = stop_req && (run_q != RUN_IDLE) &&
                      (cnt_q != CNT_FULL);
  assign do_shift = do_store || rd_low || stop_shift;

  // trace fifo, shifts toward entry 0
  generate
    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_fifo
      always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          fifo_q[i] <= 16'h0000;
        end else if (do_shift) begin
          if (i == FIFO_DEPTH - 1) begin
            fifo_q[i] <= stop_shift ? 16'h0000 : din;
          end else begin
            fifo_q[i] <= fifo_q[(i + 1) % FIFO_DEPTH];
          end
        end
      end
    end
  endgenerate

  // last opcode fetch address for profiling
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      fetch_q <= 16'h0000;
    end else if (I_CPU.valid && I_CPU.opfetch) begin
      fetch_q <= I_CPU.addr;
    end
  end

  // run sequencer
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      run_q <= RUN_IDLE;
      blank_q <= 2'h0;
    end else if (stop_req) begin
      run_q <= RUN_IDLE;
    end else if (arm_req) begin
      if (evt_mode) begin
        run_q <= RUN_STORE;
      end else if (trig_q[TRIG_BEGIN]) begin
        run_q <= RUN_WAIT;
      end else begin
        run_q <= RUN_CIRC;
      end
    end else if (!ctrl_q[CTRL_MOD_EN]) begin
      // module off; checked after arming, whose write sets the enable
      run_q <= RUN_IDLE;
    end else begin
      case (run_q)
        RUN_WAIT: begin
          if (trig) begin
            run_q <= RUN_STORE;
            blank_q <= COF_BLANK;
          end
        end
        RUN_STORE: begin
          if (blank_q != 2'h0) begin
            blank_q <= blank_q - 2'h1;
          end
          if (do_store && (cnt_q == CNT_FULL - 4'h1)) begin
            run_q <= RUN_IDLE;
          end
        end
        RUN_CIRC: begin
          if (trig) begin
            run_q <= RUN_IDLE;
          end
        end
        default: begin
          run_q <= RUN_IDLE;
        end
      endcase
    end
  end

  // hit flags and valid count, a flag set beats the arming clear, the count clear beats a store
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      af_q <= 1'b0;
      bf_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      af_q <= (af_q && !arm_req) ||
              (hit[0] && run_q != RUN_IDLE);
      bf_q <= (bf_q && !arm_req) ||
              (hit[1] && run_q != RUN_IDLE);
      if (arm_req) begin
        cnt_q <= 4'h0;
      end else if (do_store && cnt_q != CNT_FULL) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // control and comparator registers
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_q <= CTRL_RST;
      trig_q <= TRIG_RST;
      cmp_q[0] <= CMP_RST;
      cmp_q[1] <= CMP_RST;
    end else if (acc && I_PWRITE) begin
      if (I_PADDR == OFS_CTRL) begin
        ctrl_q <= I_PWDATA[7:0];
      end else if (I_PADDR == OFS_TRIG) begin
        trig_q <= I_PWDATA[7:0];
      end else if (I_PADDR == OFS_CMPA) begin
        cmp_q[0] <= I_PWDATA[15:0];
      end else if (I_PADDR == OFS_CMPB) begin
        cmp_q[1] <= I_PWDATA[15:0];
      end
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      slverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (I_PADDR == OFS_CTRL) begin
        prdata_q[7:0] <= {ctrl_q[7], run_q != RUN_IDLE, ctrl_q[5:0]};
      end else if (I_PADDR == OFS_TRIG) begin
        prdata_q[7:0] <= trig_q;
      end else if (I_PADDR == OFS_STAT) begin
        prdata_q[STAT_AF] <= af_q;
        prdata_q[STAT_BF] <= bf_q;
        prdata_q[STAT_ARM] <= (run_q != RUN_IDLE);
        prdata_q[STAT_CNT_LO +: 4] <= cnt_q;
      end else if (I_PADDR == OFS_CMPA) begin
        prdata_q[15:0] <= cmp_q[0];
      end else if (I_PADDR == OFS_CMPB) begin
        prdata_q[15:0] <= cmp_q[1];
      end else if (I_PADDR == OFS_FIFOH) begin
        prdata_q[7:0] <= fifo_q[0][15:8];
      end else if (I_PADDR == OFS_FIFOL) begin
        prdata_q[7:0] <= fifo_q[0][7:0];
      end else begin
        slverr_q <= 1'b1;
      end
    end
  end

  // break request cause
  assign brk = ctrl_q[CTRL_MOD_EN] && ctrl_q[CTRL_BRK_EN] &&
               (run_q != RUN_IDLE) &&
               ((full_mode && ctrl_q[CTRL_TAG]) ? hit[0] : trig);

  // tag pulse and held force request
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tag_q <= 1'b0;
      force_q <= 1'b0;
    end else begin
      tag_q <= brk && ctrl_q[CTRL_TAG];
      force_q <= (brk && !ctrl_q[CTRL_TAG]) ||
                 (force_q && !I_BRK_ACK);
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = slverr_q && acc;
  assign O_BRK_TAG = tag_q;
  assign O_BRK_FORCE = force_q;
  assign O_ARMED = (run_q != RUN_IDLE);

  // arming from idle clears count and raises the flag
  arm_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    arm_req && run_q == RUN_IDLE |=> O_ARMED && cnt_q == 4'h0)
    else $error("arming did not clear count");

  // a low byte read moves entry 1 to the port
  fifo_shift_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    rd_low && !stop_shift |=> fifo_q[0] == $past(fifo_q[1]))
    else $error("low read did not shift");

  // event data has an empty high byte
  evt_high_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    do_store && evt_mode |=> fifo_q[7][15:8] == 8'h00)
    else $error("event entry high byte not zero");

  // start trigger and two following cycles store nothing
  begin_blank_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    run_q == RUN_WAIT && trig && !arm_req && !stop_req
    && ctrl_q[CTRL_MOD_EN] |-> !do_store ##1 !do_store ##1 !do_store)
    else $error("stored inside blanking");

  // end trigger on a flow change stores it
  end_last_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    run_q == RUN_CIRC && trig && cof_ok |-> do_store ##1 !O_ARMED)
    else $error("end trigger flow change lost");

  // unarmed low read pushes the last fetch
  profile_push_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    rd_low && !O_ARMED |=> fifo_q[7] == $past(fetch_q))
    else $error("profile address not pushed");

  // conditional branch stores its source
  cond_src_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    do_store && !evt_mode && I_CPU.cof_kind == COF_COND
    |=> fifo_q[7] == $past(I_CPU.cof_src))
    else $error("wrong branch address stored");

  // force request held until acknowledged
  force_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    O_BRK_FORCE && !I_BRK_ACK |=> O_BRK_FORCE)
    else $error("force request dropped");

  // serial link cycles never match
  link_mask_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_ENTER_BACKGROUND_INSTR_ACCESS |-> raw == 2'b00)
    else $error("comparator matched during link access");

  // early stop inserts one empty entry
  stop_realign_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    stop_shift |=> fifo_q[7] == 16'h0000 && !O_ARMED)
    else $error("early stop not realigned");

  // count never passes the depth
  count_cap_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    cnt_q <= CNT_FULL)
    else $error("count beyond depth");

endmodule : dbgtr_top

/* File: sim/dbgtr_cpu_model.sv */
/*
 * cpu core model: one bus record a cycle, takes force breaks.
 * assumes the bench calls drive() just after a clock edge.
 */
`timescale 1ns/1ps
module dbgtr_cpu_model
  import dbgtr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_brk_force,
  output dbgtr_cpu_s o_cpu,
  output logic o_brk_ack
);
  int ack_delay = 2; // cycles left in the current instruction
  int wait_cnt = 0; // cycles since force seen
  initial begin
    o_cpu = '0;
    o_brk_ack = 1'b0;
  end
  // present one bus record for the next cycle
  task automatic drive(input dbgtr_cpu_s v);
    @(posedge i_clock);
    o_cpu <= v;
  endtask : drive
  // finish the instruction, then take the force request
  always @(posedge i_clock) begin
    o_brk_ack <= 1'b0;
    wait_cnt <= 0;
    if (i_brk_force === 1'b1 && o_brk_ack !== 1'b1) begin
      wait_cnt <= wait_cnt + 1;
      o_brk_ack <= (wait_cnt == ack_delay);
    end
  end
endmodule : dbgtr_cpu_model

/* File: sim/dbgtr_top_test.sv */
/*
 * bench of the debug trace unit: apb tasks, cpu model, trace runs.
 * assumes zero-wait apb answers and the offsets of dbgtr_pkg.
 */
`timescale 1ns/1ps
module dbgtr_top_test
  import dbgtr_pkg::*;
;
  logic clock = 1'b0; // 25 mhz clock
  logic resetn = 1'b0; // active low reset
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enter_background_instr = 1'b0; // serial link access
  logic brk_tag;
  logic brk_force;
  logic brk_ack;
  logic armed;
  dbgtr_cpu_s cpu;
  dbgtr_cpu_s ex; // opcode execution record
  int n_mismatch = 0;
  int checks = 0;
  int n_tag = 0; // tag pulses seen
  int tags; // tag count before a probe
  int exp_tag[10] = '{1, 3, 1, 1, 1, 2, 1, 3, 1, 1};
  logic [31:0] rdv; // last read data
  logic errv; // last error flag

  always #20 clock = ~clock;
  // count one-cycle tag requests
  always @(posedge clock) begin
    if (brk_tag === 1'b1)
      n_tag <= n_tag + 1;
  end

  dbgtr_top u_dut (
    .I_CLOCK(clock), .I_RESETN(resetn), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_CPU(cpu), .I_ENTER_BACKGROUND_INSTR_ACCESS(enter_background_instr),
    .I_BRK_ACK(brk_ack), .O_BRK_TAG(brk_tag),
    .O_BRK_FORCE(brk_force), .O_ARMED(armed)
  );
  dbgtr_cpu_model u_cpu (
    .i_clock(clock), .i_brk_force(brk_force), .o_cpu(cpu),
    .o_brk_ack(brk_ack)
  );

  // opcode fetch or data bus cycle
  function automatic dbgtr_cpu_s bus(logic [15:0] a, logic [7:0] d,
      logic rd);
    bus = '0;
    bus.valid = 1'b1;
    bus.addr = a;
    bus.rdata = d;
    bus.wdata = d;
    bus.rd = rd;
    bus.opfetch = rd;
  endfunction : bus
  // change of flow at source address s
  function automatic dbgtr_cpu_s cof(dbgtr_cof_e k, logic [15:0] s,
      logic [15:0] t);
    cof = bus(s, 8'h00, 1'b1);
    cof.cof_valid = 1'b1;
    cof.cof_kind = k;
    cof.cof_src = s;
    cof.cof_dst = t;
  endfunction : cof
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read", rdv, exp);
  endtask : rchk
  // one trace word, high byte first
  task automatic word(input logic [15:0] exp);
    rchk(OFS_FIFOH, {24'h0, exp[15:8]});
    rchk(OFS_FIFOL, {24'h0, exp[7:0]});
  endtask : word
  task automatic dummy(input int n);
    repeat (n) apb(1'b0, OFS_FIFOL, 32'h0);
  endtask : dummy
  task automatic idle(input int n);
    repeat (n) u_cpu.drive('0);
  endtask : idle
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // watchdog against a hang
  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    rchk(OFS_TRIG, 32'h0);
    apb(1'b1, OFS_STAT, 32'hff);
    rchk(OFS_STAT, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("error", errv, 1'b1);
    // unarmed reads fill the fifo with fetch addresses
    for (int i = 0; i < 9; i++) begin
      u_cpu.drive(bus(16'h1000 + 16'(i), 8'h00, 1'b1));
      idle(1);
      if (i < 8)
        dummy(1);
    end
    word(16'h1000);
    // end trace stopped by a change of flow
    apb(1'b1, OFS_CMPA, 32'h4000);
    apb(1'b1, OFS_TRIG, 32'h00);
    apb(1'b1, OFS_CTRL, 32'hc0);
    u_cpu.drive(cof(COF_COND, 16'h1100, 16'h1200));
    u_cpu.drive(cof(COF_UNCOND, 16'h1300, 16'h1400));
    u_cpu.drive(cof(COF_INDIRECT, 16'h1500, 16'h1600));
    u_cpu.drive(cof(COF_RETURN, 16'h4000, 16'h1700));
    idle(2);
    chk("armed", armed, 1'b0);
    rchk(OFS_STAT, 32'h83);
    dummy(5);
    word(16'h1100);
    word(16'h1600);
    word(16'h1700);
    // manual stop before full
    apb(1'b1, OFS_CTRL, 32'hc0);
    u_cpu.drive(cof(COF_COND, 16'h2100, 16'h0));
    u_cpu.drive(cof(COF_INDIRECT, 16'h2150, 16'h2200));
    idle(1);
    apb(1'b1, OFS_CTRL, 32'h80);
    rchk(OFS_STAT, 32'h02);
    dummy(5);
    word(16'h2100);
    word(16'h2200);
    // begin trace, blanked after trigger, ends when full
    apb(1'b1, OFS_TRIG, 32'h40);
    apb(1'b1, OFS_CTRL, 32'hc0);
    u_cpu.drive(cof(COF_COND, 16'h4000, 16'h0));
    u_cpu.drive(cof(COF_COND, 16'h3001, 16'h0));
    u_cpu.drive(cof(COF_COND, 16'h3002, 16'h0));
    for (int i = 0; i < 9; i++)
      u_cpu.drive(cof(COF_COND, 16'h3100 + 16'(i), 16'h0));
    idle(2);
    rchk(OFS_STAT, 32'h88);
    for (int i = 0; i < 8; i++)
      word(16'h3100 + 16'(i));
    // event only capture, begin bit clear
    apb(1'b1, OFS_CMPB, 32'h5000);
    apb(1'b1, OFS_TRIG, 32'h05);
    apb(1'b1, OFS_CTRL, 32'hc0);
    u_cpu.drive(bus(16'h5001, 8'hee, 1'b1));
    for (int i = 0; i < 9; i++)
      u_cpu.drive(bus(16'h5000, 8'h20 + 8'(i), 1'b1));
    idle(2);
    rchk(OFS_STAT, 32'h48);
    rchk(OFS_FIFOH, 32'h0);
    for (int i = 0; i < 8; i++)
      rchk(OFS_FIFOL, 32'h20 + i);
    // every mode code against one probe sequence
    apb(1'b1, OFS_CMPA, 32'h2000);
    apb(1'b1, OFS_CMPB, 32'h2010);
    for (int m = 0; m < 10; m++) begin
      tags = n_tag;
      apb(1'b1, OFS_TRIG, 32'h40 + m);
      apb(1'b1, OFS_CTRL, 32'hf0);
      u_cpu.drive(bus(16'h2010, 8'h00, 1'b1));
      u_cpu.drive(bus(16'h2000, 8'h00, 1'b1));
      u_cpu.drive(bus(16'h2010, 8'h00, 1'b1));
      u_cpu.drive(bus(16'h3000, 8'h00, 1'b1));
      idle(3);
      chk("tags", n_tag - tags, exp_tag[m]);
      apb(1'b1, OFS_CTRL, 32'h00);
    end
    // opcode qualified trigger fires on execution, not on fetch
    apb(1'b1, OFS_TRIG, 32'h80);
    apb(1'b1, OFS_CTRL, 32'hf0);
    tags = n_tag;
    u_cpu.drive(bus(16'h2000, 8'h00, 1'b1));
    idle(3);
    chk("qualified fetch", n_tag - tags, 0);
    ex = '0;
    ex.exec = 1'b1;
    ex.exec_addr = 16'h2000;
    u_cpu.drive(ex);
    idle(3);
    chk("qualified exec", n_tag - tags, 1);
    // full mode end trace needs address and data in one cycle
    apb(1'b1, OFS_TRIG, 32'h03);
    apb(1'b1, OFS_CTRL, 32'hc0);
    u_cpu.drive(bus(16'h2000, 8'h11, 1'b1));
    idle(2);
    chk("full miss", armed, 1'b1);
    u_cpu.drive(bus(16'h2000, 8'h10, 1'b1));
    idle(2);
    chk("full hit", armed, 1'b0);
    // force break: direction, serial mask, hold until ack
    apb(1'b1, OFS_TRIG, 32'h00);
    apb(1'b1, OFS_CTRL, 32'hdc);
    u_cpu.drive(bus(16'h2000, 8'h00, 1'b0));
    u_cpu.drive(bus(16'h2000, 8'h00, 1'b1));
    enter_background_instr <= 1'b1;
    idle(2);
    enter_background_instr <= 1'b0;
    chk("force", brk_force, 1'b0);
    u_cpu.drive(bus(16'h2000, 8'h00, 1'b1));
    idle(1);
    #1;
    chk("force", brk_force, 1'b1);
    idle(2);
    #1;
    chk("force", brk_force, 1'b1);
    for (int k = 0; k < 10 && brk_force !== 1'b0; k++) begin
      @(posedge clock);
      #1;
    end
    chk("force", brk_force, 1'b0);
    close_out();
  end
endmodule : dbgtr_top_test
